// *** logic/pic_interrupt_control_status.sv ***
// Interrupt control and status register with its interrupt output
`timescale 1ns/1ps
`default_nettype none

module pic_irq_csr (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Host register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [3:0] reg_be,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	// Event pulses from counters and master logic
	input wire logic rd_count_zero,
	input wire logic wr_count_zero,
	input wire logic target_abort,
	input wire logic master_abort,
	// Add-on mailbox accesses
	input wire logic inbox_wr,
	input wire logic [1:0] inbox_num,
	input wire logic [3:0] inbox_be,
	input wire logic outbox_rd,
	input wire logic [1:0] outbox_num,
	input wire logic [3:0] outbox_be,
	// Open-drain interrupt pin, low when driven
	output logic int_out,
	output logic int_oe
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	// All state of the block
	typedef struct packed {
		logic [5:0] status; // Latched conditions, bits 21..16
		logic rdone_en; // Read-complete enable
		logic wdone_en; // Write-complete enable
		logic in_en; // Incoming mailbox enable
		logic [1:0] in_box; // Incoming mailbox select
		logic [1:0] in_byte; // Incoming byte select
		logic out_en; // Outgoing mailbox enable
		logic [1:0] out_box; // Outgoing mailbox select
		logic [1:0] out_byte; // Outgoing byte select
		logic [31:0] rdata; // Read answer
		logic rvalid; // Read answer valid
		logic irq; // Registered interrupt request
	} pic_state_t;

	pic_state_t st_q; // Registered state
	pic_state_t st_d; // Next state
	logic in_hit; // Selected incoming byte written
	logic out_hit; // Selected outgoing byte read
	logic csr_sel; // Access addresses this register
	logic [5:0] ev; // Event pulses in status order
	logic [31:0] csr_view; // Register as read

	////////////////////////////////////////////////////////////////////////////////
	// Mailbox matching

	// Incoming mailbox byte written by the add-on side
	pic_mbox_match u_in_match (
		.strobe(inbox_wr),
		.box(inbox_num),
		.byte_en(inbox_be),
		.sel_box(st_q.in_box),
		.sel_byte(st_q.in_byte),
		.hit(in_hit)
	);

	// Outgoing mailbox byte read by the add-on side
	pic_mbox_match u_out_match (
		.strobe(outbox_rd),
		.box(outbox_num),
		.byte_en(outbox_be),
		.sel_box(st_q.out_box),
		.sel_byte(st_q.out_byte),
		.hit(out_hit)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read view and next state

	// Register image; fields 31:24, 22, 13 and 7:5 read zero
	always_comb begin
		csr_view = 32'h0000_0000;
		csr_view[pic_pkg::PIC_SUMMARY_BIT] = |st_q.status[3:0];
		csr_view[pic_pkg::PIC_TABORT_BIT:pic_pkg::PIC_STATUS_LSB] = st_q.status;
		csr_view[pic_pkg::PIC_RDONE_EN_BIT] = st_q.rdone_en;
		csr_view[pic_pkg::PIC_WDONE_EN_BIT] = st_q.wdone_en;
		csr_view[pic_pkg::PIC_INBOX_EN_BIT] = st_q.in_en;
		csr_view[pic_pkg::PIC_INBOX_BOX_LSB +: 2] = st_q.in_box;
		csr_view[pic_pkg::PIC_INBOX_BYTE_LSB +: 2] = st_q.in_byte;
		csr_view[pic_pkg::PIC_OUTBOX_EN_BIT] = st_q.out_en;
		csr_view[pic_pkg::PIC_OUTBOX_BOX_LSB +: 2] = st_q.out_box;
		csr_view[pic_pkg::PIC_OUTBOX_BYTE_LSB +: 2] = st_q.out_byte;
	end

	// Address decode and event collection
	always_comb begin
		csr_sel = (reg_addr == pic_pkg::PIC_CSR_OFFSET);
		ev = {target_abort, master_abort, rd_count_zero, wr_count_zero, in_hit, out_hit};
	end

	// Next-state logic
	always_comb begin
		st_d = st_q;
		// Write-one-clear, only through the status byte lane
		if (reg_wr && csr_sel && reg_be[pic_pkg::PIC_LANE_STATUS]) begin
			st_d.status = st_q.status & ~reg_wdata[pic_pkg::PIC_TABORT_BIT:pic_pkg::PIC_STATUS_LSB];
		end
		// Set applied after clear so a same-cycle event is never lost
		st_d.status = st_d.status | ev;
		// Enable and select bits per byte lane
		if (reg_wr && csr_sel && reg_be[pic_pkg::PIC_LANE_INCTL]) begin
			st_d.rdone_en = reg_wdata[pic_pkg::PIC_RDONE_EN_BIT];
			st_d.wdone_en = reg_wdata[pic_pkg::PIC_WDONE_EN_BIT];
			st_d.in_en = reg_wdata[pic_pkg::PIC_INBOX_EN_BIT];
			st_d.in_box = reg_wdata[pic_pkg::PIC_INBOX_BOX_LSB +: 2];
			st_d.in_byte = reg_wdata[pic_pkg::PIC_INBOX_BYTE_LSB +: 2];
		end
		if (reg_wr && csr_sel && reg_be[pic_pkg::PIC_LANE_OUTCTL]) begin
			st_d.out_en = reg_wdata[pic_pkg::PIC_OUTBOX_EN_BIT];
			st_d.out_box = reg_wdata[pic_pkg::PIC_OUTBOX_BOX_LSB +: 2];
			st_d.out_byte = reg_wdata[pic_pkg::PIC_OUTBOX_BYTE_LSB +: 2];
		end
		// Read answer one cycle after the strobe; unmapped reads return zero
		st_d.rvalid = reg_rd;
		if (reg_rd) begin
			st_d.rdata = csr_sel ? csr_view : 32'h0000_0000;
		end
		// Aborts always interrupt; the other four pass their enables
		st_d.irq = st_d.status[5] | st_d.status[4]
			| (st_d.status[3] & st_d.rdone_en)
			| (st_d.status[2] & st_d.wdone_en)
			| (st_d.status[1] & st_d.in_en)
			| (st_d.status[0] & st_d.out_en);
	end

	// State register; everything resets to zero, enables off
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	// Pin only pulled low; the wire's pull-up gives the idle level
	always_comb begin
		reg_rdata = st_q.rdata;
		reg_rvalid = st_q.rvalid;
		int_out = 1'b0;
		int_oe = st_q.irq;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	summary_or_a: assert property (@(posedge mclk) disable iff (!rst_b)
		reg_rvalid && $past(reg_addr) == pic_pkg::PIC_CSR_OFFSET
		|-> reg_rdata[pic_pkg::PIC_SUMMARY_BIT] == |reg_rdata[19:16])
		else $error("summary bit differs from OR of conditions");

	tabort_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
		target_abort |=> st_q.status[5])
		else $error("target abort not latched");

	mabort_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
		master_abort |=> st_q.status[4])
		else $error("master abort not latched");

	woc_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
		reg_wr && csr_sel && reg_be[2] && reg_wdata[19] && !rd_count_zero
		|=> !st_q.status[3])
		else $error("write one did not clear read-complete");

	woc_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_q.status[2] && !(reg_wr && csr_sel && reg_be[2] && reg_wdata[18])
		|=> st_q.status[2])
		else $error("write-complete cleared without a written one");

	rdone_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
		rd_count_zero ##1 (st_q.rdone_en && !reg_wr) |-> int_oe)
		else $error("enabled read-complete did not interrupt");

	// Latched write-complete alone, with its enable off, must leave the pin released
	wdone_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_q.status[2] && !st_q.wdone_en && st_q.status[5:3] == 3'b000
		&& !(st_q.status[1] && st_q.in_en) && !(st_q.status[0] && st_q.out_en)
		|-> !int_oe)
		else $error("disabled write-complete raised the interrupt");

	wdone_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
		wr_count_zero ##1 st_q.wdone_en |-> st_q.status[2] && int_oe)
		else $error("enabled write-complete did not interrupt");

	inbox_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
		inbox_wr && inbox_num == st_q.in_box && inbox_be[st_q.in_byte]
		|=> st_q.status[1])
		else $error("selected incoming mailbox write not latched");

	outbox_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
		outbox_rd && outbox_num == st_q.out_box && outbox_be[st_q.out_byte]
		|=> st_q.status[0])
		else $error("selected outgoing mailbox read not latched");

	irq_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_q.status[1] && st_q.in_en |-> int_oe)
		else $error("interrupt dropped while enabled condition latched");

	outbox_en_a: assert property (@(posedge mclk) disable iff (!rst_b)
		st_q.status[0] && st_q.out_en |-> int_oe)
		else $error("outgoing mailbox interrupt not raised");

	reserved_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
		reg_rvalid |-> reg_rdata[31:24] == 8'h00 && !reg_rdata[22]
		&& !reg_rdata[13] && reg_rdata[7:5] == 3'h0)
		else $error("reserved bits read non-zero");

	set_wins_a: assert property (@(posedge mclk) disable iff (!rst_b)
		master_abort && reg_wr && csr_sel && reg_be[2] && reg_wdata[20]
		|=> st_q.status[4])
		else $error("event lost to simultaneous clear");

	irq_cycle_c: cover property (@(posedge mclk) disable iff (!rst_b)
		rd_count_zero ##1 int_oe ##[1:5] !int_oe);
	inbox_c: cover property (@(posedge mclk) disable iff (!rst_b) in_hit && st_q.in_en);
	collide_c: cover property (@(posedge mclk) disable iff (!rst_b)
		target_abort && reg_wr && csr_sel && reg_wdata[21]);

endmodule
`default_nettype wire

// *** logic/pic_mbox_match.sv ***
// Match of one add-on mailbox access against the selected mailbox and byte
`timescale 1ns/1ps
`default_nettype none

module pic_mbox_match (
	// Add-on mailbox access
	input wire logic strobe,
	input wire logic [1:0] box,
	input wire logic [3:0] byte_en,
	// Selection from the register
	input wire logic [1:0] sel_box,
	input wire logic [1:0] sel_byte,
	// One-cycle match pulse
	output logic hit
);

	// Codes 0..3 stand for mailboxes one to four and bytes 0 to 3
	always_comb begin
		hit = strobe && (box == sel_box) && byte_en[sel_byte];
	end

endmodule
`default_nettype wire

// *** logic/pic_pkg.sv ***
// Constants for the interrupt control and status register block
package pic_pkg;

	// Register placement and value after reset
	localparam logic [7:0] PIC_CSR_OFFSET = 8'h38;
	localparam logic [31:0] PIC_CSR_RESET = 32'h0000_0000;

	// Status bit positions
	localparam int PIC_SUMMARY_BIT = 23;
	localparam int PIC_TABORT_BIT = 21;
	localparam int PIC_MABORT_BIT = 20;
	localparam int PIC_RDONE_BIT = 19;
	localparam int PIC_WDONE_BIT = 18;
	localparam int PIC_INBOX_BIT = 17;
	localparam int PIC_OUTBOX_BIT = 16;
	localparam int PIC_STATUS_LSB = 16;

	// Control bit and field positions
	localparam int PIC_RDONE_EN_BIT = 15;
	localparam int PIC_WDONE_EN_BIT = 14;
	localparam int PIC_INBOX_EN_BIT = 12;
	localparam int PIC_INBOX_BOX_LSB = 10;
	localparam int PIC_INBOX_BYTE_LSB = 8;
	localparam int PIC_OUTBOX_EN_BIT = 4;
	localparam int PIC_OUTBOX_BOX_LSB = 2;
	localparam int PIC_OUTBOX_BYTE_LSB = 0;

	// Byte lanes of the register port
	localparam int PIC_LANE_STATUS = 2;
	localparam int PIC_LANE_INCTL = 1;
	localparam int PIC_LANE_OUTCTL = 0;

endpackage

// *** verification/pci_interrupt_control_status_bench.sv ***
// Self-checking bench for the interrupt control and status register
`timescale 1ns/1ps
`default_nettype none

module pci_interrupt_control_status_bench;
	// Clock, reset and event pulses, driven at the falling edge
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic rd_count_zero = 1'b0, wr_count_zero = 1'b0, target_abort = 1'b0;
	logic master_abort = 1'b0, inbox_wr = 1'b0, outbox_rd = 1'b0;
	logic [1:0] inbox_num = 2'h0, outbox_num = 2'h0;
	logic [3:0] inbox_be = 4'h0, outbox_be = 4'h0;
	// Register port and interrupt pin
	logic reg_wr, reg_rd, reg_rvalid, int_out, int_oe, int_line;
	logic [7:0] reg_addr;
	logic [3:0] reg_be;
	logic [31:0] reg_wdata, reg_rdata;
	// Score and expected register image
	int err_total = 0;
	int checks = 0;
	logic [31:0] model_reg = 32'h0;

	always #5 mclk = ~mclk;

	pic_irq_csr i_dut (.mclk(mclk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .rd_count_zero(rd_count_zero), .wr_count_zero(wr_count_zero),
		.target_abort(target_abort), .master_abort(master_abort), .inbox_wr(inbox_wr),
		.inbox_num(inbox_num), .inbox_be(inbox_be), .outbox_rd(outbox_rd),
		.outbox_num(outbox_num), .outbox_be(outbox_be), .int_out(int_out), .int_oe(int_oe));
	pic_host_model i_host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.int_out(int_out), .int_oe(int_oe), .int_line(int_line));

	////////////////////////////////////////////////////////////////////////////////
	// Expected register after one cycle; event set wins over a written clear
	function automatic logic [31:0] step(input logic [31:0] r, input logic [5:0] ev,
		input logic we, input logic [3:0] be, input logic [31:0] d);
		logic [5:0] st;
		st = (we && be[2]) ? (r[21:16] & ~d[21:16]) : r[21:16];
		st = st | ev;
		if (we && be[1]) r[15:8] = d[15:8] & 8'hDF;
		if (we && be[0]) r[7:0] = d[7:0] & 8'h1F;
		return {8'h0, |st[3:0], 1'b0, st, r[15:0]};
	endfunction

	// Pin level expected from the latched and enabled conditions
	function automatic logic int_exp(input logic [31:0] r);
		return ~(r[21] | r[20] | (r[19] & r[15]) | (r[18] & r[14]) | (r[17] & r[12]) | (r[16] & r[4]));
	endfunction

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Read back a register and the pin
	task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic v;
		i_host.rd(a, d, v);
		check("rvalid", 32'h1, {31'h0, v});
		check("rdata", exp, d);
		check("int_line", {31'h0, int_exp(model_reg)}, {31'h0, int_line});
	endtask

	// One cycle of event pulses and an optional write, then a read-back;
	// aim steers mailbox accesses onto the selected box and byte
	task automatic cycle(input logic [5:0] ev, input logic we, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] d, input logic aim);
		logic hi, ho;
		{target_abort, master_abort, rd_count_zero, wr_count_zero, inbox_wr, outbox_rd} = ev;
		inbox_num = aim ? model_reg[11:10] : 2'($urandom_range(3));
		outbox_num = aim ? model_reg[3:2] : 2'($urandom_range(3));
		inbox_be = aim ? (4'h1 << model_reg[9:8]) : 4'($urandom_range(15));
		outbox_be = aim ? (4'h1 << model_reg[1:0]) : 4'($urandom_range(15));
		hi = ev[1] && inbox_num == model_reg[11:10] && inbox_be[model_reg[9:8]];
		ho = ev[0] && outbox_num == model_reg[3:2] && outbox_be[model_reg[1:0]];
		model_reg = step(model_reg, {ev[5:2], hi, ho}, we && a == 8'h38, be, d);
		if (we) i_host.wr(a, be, d);
		else @(negedge mclk);
		{target_abort, master_abort, rd_count_zero, wr_count_zero, inbox_wr, outbox_rd} = 6'h0;
		read_check(8'h38, model_reg);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(33));
		repeat (3) @(negedge mclk);
		rst_b = 1'b1;
		read_check(8'h38, 32'h0);
		$display("test reset done");
		cycle(6'h0, 1'b1, 8'h38, 4'hF, 32'hFFFFFFFF, 1'b0);
		for (int k = 0; k < 6; k++) begin
			cycle(6'h1 << k, 1'b0, 8'h38, 4'h0, 32'h0,
				1'b1);
			cycle(6'h0, 1'b1, 8'h38, 4'h4, 32'h1 << (16 + k), 1'b0);
		end
		cycle(6'h3F, 1'b1, 8'h38, 4'h4, 32'h003F0000, 1'b1);
		read_check(8'h3C, 32'h0);
		$display("test corners done");
		// Each pass first clears every latched condition, so a missing set shows up
		for (int s = 0; s < 16; s++) begin
			cycle(6'h0, 1'b1, 8'h38, 4'h7, {8'h00, 8'h3F, 4'h1, 4'(s), 4'h1, 4'(s)},
				1'b0);
			cycle(6'h03, 1'b0, 8'h38, 4'h0, 32'h0, 1'b1);
			cycle(6'h0, 1'b1, 8'h38, 4'h4, 32'h003F0000, 1'b0);
		end
		$display("test mailbox select done");
		for (int i = 0; i < 300; i++) begin
			cycle(6'($urandom), 1'($urandom), $urandom_range(1) ? 8'h38 : 8'h3C,
				4'($urandom), $urandom, 1'($urandom));
		end
		$display("test random done");
		// Reset in mid-run with conditions latched and enables set
		cycle(6'h3F, 1'b1, 8'h38, 4'h3, 32'h0000D01F, 1'b1);
		rst_b = 1'b0;
		model_reg = 32'h0;
		repeat (3) @(negedge mclk);
		rst_b = 1'b1;
		read_check(8'h38, 32'h0);
		$display("test mid-run reset done");
		give_verdict();
	end

	// Watchdog well beyond the expected run of about 1100 cycles
	initial begin
		#100000;
		err_total++;
		$display("BAD watchdog expected finish seen hang");
		give_verdict();
	end
endmodule
`default_nettype wire

// *** verification/pic_host_model.sv ***
// Host-side model: register bus master and the pulled-up interrupt line
`timescale 1ns/1ps
`default_nettype none

module pic_host_model (
	// Clock
	input wire logic mclk,
	// Register port toward the block
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [3:0] reg_be,
	output logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	// Open-drain interrupt pin
	input wire logic int_out,
	input wire logic int_oe,
	output logic int_line
);
	// Pull-up holds the line high unless the block drives it
	assign int_line = int_oe ? int_out : 1'b1;

	// Idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_be = 4'h0;
		reg_wdata = 32'h0;
	end

	// One write pulse, entered at a falling edge; a one clears status
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_be = be;
		reg_wdata = d;
		@(negedge mclk);
		reg_wr = 1'b0;
		// Released data no longer shows the last value
		reg_wdata = ~d;
	endtask

	// One read pulse; the answer stands only in the cycle after the strobe is taken,
	// so it is caught at the next falling edge, then one edge passes before returning
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge mclk);
		v = reg_rvalid;
		d = reg_rdata;
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(negedge mclk);
	endtask
endmodule
`default_nettype wire
